// file: include/rtcca_defines.vh
`ifndef RTCCA_DEFINES_VH
`define RTCCA_DEFINES_VH

// Register offsets on the I/O bus
`define RTCCA_OFS_DAY    16'h00E4
`define RTCCA_OFS_MONTH  16'h00E5
`define RTCCA_OFS_YEAR   16'h00E6
`define RTCCA_OFS_HUNDR  16'h00E7
`define RTCCA_OFS_ALM_S  16'h00E8
`define RTCCA_OFS_ALM_M  16'h00E9

// Control register field positions
`define RTCCA_CTRL_UNLOCK 0
`define RTCCA_CTRL_BCD_EN 5

// Count limits in binary
`define RTCCA_DAY_MIN    8'h01
`define RTCCA_MONTH_MIN  8'h01
`define RTCCA_MONTH_MAX  8'h0C
`define RTCCA_YEAR_MIN   8'h00
`define RTCCA_YEAR_MAX   8'h63

// Value read at an unmapped address
`define RTCCA_UNMAPPED   8'h00

`endif

// file: logic/rtcca_digit_inc.v
`timescale 1ns/10ps
`default_nettype none

// One calendar field: decodes its value and forms the incremented value with wrap
module rtcca_digit_inc (
  // Field value and format
  input  wire [7:0] val,
  input  wire       bcd,
  // Limits in binary
  input  wire [7:0] min_bin,
  input  wire [7:0] max_bin,
  // Results
  output wire [7:0] val_bin,
  output wire [7:0] next_val,
  output wire       wrap
);

  // Packed BCD to binary
  function [7:0] bcd2bin;
    input [7:0] v;
    begin
      bcd2bin = {4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]};
    end
  endfunction

  // Binary (0..99) to packed BCD
  function [7:0] bin2bcd;
    input [7:0] v;
    reg   [7:0] t;
    begin
      t = v / 8'h0A;
      bin2bcd = {t[3:0], 4'h0} | (v - t * 8'h0A);
    end
  endfunction

  wire [7:0] inc_bin;

  // Decode, compare against the limit and re-encode
  assign val_bin  = bcd ? bcd2bin(val) : val;
  assign wrap     = (val_bin >= max_bin);
  assign inc_bin  = wrap ? min_bin : val_bin + 8'h01;
  assign next_val = bcd ? bin2bcd(inc_bin) : inc_bin;

endmodule // rtcca_digit_inc

`default_nettype wire

// file: logic/rtcca_month_len.v
`timescale 1ns/10ps
`default_nettype none

// Last day of the current month, leap years included
module rtcca_month_len (
  // Binary month, year and hundred-year counts
  input  wire [7:0] month_bin,
  input  wire [7:0] year_bin,
  input  wire [7:0] hundr_bin,
  // Last valid day, binary
  output reg  [7:0] last_day
);

  wire leap;

  // Year 00 is a leap year only when the hundred-year count is a multiple of four
  assign leap = (year_bin[1:0] == 2'b00) &&
                ((year_bin != 8'h00) || (hundr_bin[1:0] == 2'b00));

  // Month length table
  always @* begin
    case (month_bin)
      8'h02:   last_day = leap ? 8'h1D : 8'h1C;
      8'h04,
      8'h06,
      8'h09,
      8'h0B:   last_day = 8'h1E;
      default: last_day = 8'h1F;
    endcase
  end

endmodule // rtcca_month_len

`default_nettype wire

// file: logic/rtcca_top.v
`timescale 1ns/10ps
`default_nettype none
`include "rtcca_defines.vh"

// Calendar counts and alarm second/minute targets of the real-time clock
module rtcca_top (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // I/O register bus
  input  wire [15:0] io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  output wire        io_hit,
  // Control register contents and alarm enables
  input  wire [7:0]  ctrl_reg,
  input  wire        alm_s_en,
  input  wire        alm_m_en,
  // Time-of-day side
  input  wire        count_tick,
  input  wire        day_carry,
  input  wire [7:0]  sec_count,
  input  wire [7:0]  min_count,
  // Compare and carry outputs
  output reg         alarm_s_match,
  output reg         alarm_m_match,
  output reg         alarm_sm_match,
  output reg         hundr_carry
);

  localparam NF = 4;

  // Register storage, no reset on purpose except unlock_q
  reg  [7:0] day_of_month_count;
  reg  [7:0] month_count;
  reg  [7:0] year_count;
  reg  [7:0] hundred_year_count;
  reg  [7:0] alarm_s_target;
  reg  [7:0] alarm_m_target;
  reg        unlock_q;

  wire       unlock;
  wire       bcd_en;
  wire       relock;
  wire       day_adv;
  wire [7:0] last_day;

  // Per-field vectors, index 0 day .. 3 hundred-year
  wire [8*NF-1:0] cur_v;
  wire [8*NF-1:0] min_v;
  wire [8*NF-1:0] max_v;
  wire [8*NF-1:0] bin_v;
  wire [8*NF-1:0] nxt_v;
  wire [NF-1:0]   wrap_v;
  wire [NF-1:0]   adv_v;

  // Control fields
  assign unlock = ctrl_reg[`RTCCA_CTRL_UNLOCK];
  assign bcd_en = ctrl_reg[`RTCCA_CTRL_BCD_EN];
  assign relock = unlock_q & ~unlock;

  // Address decode
  function is_ofs;
    input [15:0] a;
    input [15:0] o;
    begin
      is_ofs = (a == o);
    end
  endfunction

  assign io_hit = is_ofs(io_addr, `RTCCA_OFS_DAY)   | is_ofs(io_addr, `RTCCA_OFS_MONTH) |
                  is_ofs(io_addr, `RTCCA_OFS_YEAR)  | is_ofs(io_addr, `RTCCA_OFS_HUNDR) |
                  is_ofs(io_addr, `RTCCA_OFS_ALM_S) | is_ofs(io_addr, `RTCCA_OFS_ALM_M);

  // Field inputs and limits
  assign cur_v = {hundred_year_count, year_count, month_count, day_of_month_count};
  assign min_v = {`RTCCA_YEAR_MIN, `RTCCA_YEAR_MIN, `RTCCA_MONTH_MIN, `RTCCA_DAY_MIN};
  assign max_v = {`RTCCA_YEAR_MAX, `RTCCA_YEAR_MAX, `RTCCA_MONTH_MAX, last_day};

  // Counting only while locked
  assign day_adv = day_carry & ~unlock;

  // Carry chain and per-field increment
  genvar g;
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_field
      if (g == 0) begin : g_first
        assign adv_v[g] = day_adv;
      end else begin : g_rest
        assign adv_v[g] = adv_v[g-1] & wrap_v[g-1];
      end
      rtcca_digit_inc u_inc (
        .val      (cur_v[8*g +: 8]),
        .bcd      (bcd_en),
        .min_bin  (min_v[8*g +: 8]),
        .max_bin  (max_v[8*g +: 8]),
        .val_bin  (bin_v[8*g +: 8]),
        .next_val (nxt_v[8*g +: 8]),
        .wrap     (wrap_v[g])
      );
    end
  endgenerate

  // Month length from the decoded counts
  rtcca_month_len u_mlen (
    .month_bin (bin_v[15:8]),
    .year_bin  (bin_v[23:16]),
    .hundr_bin (bin_v[31:24]),
    .last_day  (last_day)
  );

  // Calendar counts: CPU write while unlocked, else advance on carry
  always @(posedge clk) begin
    if (io_wr && unlock) begin
      if (is_ofs(io_addr, `RTCCA_OFS_DAY))
        day_of_month_count <= io_wdata;
      if (is_ofs(io_addr, `RTCCA_OFS_MONTH))
        month_count <= io_wdata;
      if (is_ofs(io_addr, `RTCCA_OFS_YEAR))
        year_count <= io_wdata;
      if (is_ofs(io_addr, `RTCCA_OFS_HUNDR))
        hundred_year_count <= io_wdata;
    end else begin
      if (adv_v[0])
        day_of_month_count <= nxt_v[7:0];
      if (adv_v[1])
        month_count <= nxt_v[15:8];
      if (adv_v[2])
        year_count <= nxt_v[23:16];
      if (adv_v[3])
        hundred_year_count <= nxt_v[31:24];
    end
  end

  // Alarm targets: writable at any time, untouched by reset
  always @(posedge clk) begin
    if (io_wr && is_ofs(io_addr, `RTCCA_OFS_ALM_S))
      alarm_s_target <= io_wdata;
    if (io_wr && is_ofs(io_addr, `RTCCA_OFS_ALM_M))
      alarm_m_target <= io_wdata;
  end

  // Read data, registered; unmapped addresses read as zero
  always @(posedge clk) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (1'b1)
        is_ofs(io_addr, `RTCCA_OFS_DAY):   io_rdata <= day_of_month_count;
        is_ofs(io_addr, `RTCCA_OFS_MONTH): io_rdata <= month_count;
        is_ofs(io_addr, `RTCCA_OFS_YEAR):  io_rdata <= year_count;
        is_ofs(io_addr, `RTCCA_OFS_HUNDR): io_rdata <= hundred_year_count;
        is_ofs(io_addr, `RTCCA_OFS_ALM_S): io_rdata <= alarm_s_target;
        is_ofs(io_addr, `RTCCA_OFS_ALM_M): io_rdata <= alarm_m_target;
        default:                           io_rdata <= `RTCCA_UNMAPPED;
      endcase
    end
  end

  // Unlock history for the relock edge
  always @(posedge clk) begin
    if (rst)
      unlock_q <= 1'b0;
    else
      unlock_q <= unlock;
  end

  // Alarm compare on every increment and on relock
  always @(posedge clk) begin
    if (rst) begin
      alarm_s_match  <= 1'b0;
      alarm_m_match  <= 1'b0;
      alarm_sm_match <= 1'b0;
    end else if ((count_tick && !unlock) || relock) begin
      alarm_s_match  <= alm_s_en && (sec_count == alarm_s_target);
      alarm_m_match  <= alm_m_en && (min_count == alarm_m_target);
      alarm_sm_match <= (alm_s_en || alm_m_en) &&
                        (!alm_s_en || (sec_count == alarm_s_target)) &&
                        (!alm_m_en || (min_count == alarm_m_target));
    end
  end

  // Hundred-year wrap pulse
  always @(posedge clk) begin
    if (rst)
      hundr_carry <= 1'b0;
    else
      hundr_carry <= adv_v[3] & wrap_v[3] & ~(io_wr & unlock);
  end

endmodule // rtcca_top

`default_nettype wire

// file: verification/rtcca_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the calendar and alarm slice
module rtcca_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  // Control and time side
  input wire logic [7:0]  ctrl_reg,
  input wire logic        alm_s_en,
  input wire logic        alm_m_en,
  input wire logic        count_tick,
  input wire logic        day_carry,
  // Outputs under check
  input wire logic        alarm_s_match,
  input wire logic        alarm_m_match,
  input wire logic        alarm_sm_match,
  input wire logic        hundr_carry
);
  logic unl_q;
  logic ev;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Unlock state one cycle back, and the edges that evaluate the alarm
  always @(posedge clk) unl_q <= ctrl_reg[0];
  assign ev = !ctrl_reg[0] && (count_tick || unl_q);
  property p_unwr;
    io_wr && ctrl_reg[0] && io_addr == 16'h00E4 ##1 io_rd && !io_wr && io_addr == 16'h00E4
    |=> io_rdata == $past(io_wdata, 2);
  endproperty
  a_unwr: assert property (p_unwr) else $error("unlocked day write lost");
  property p_lkwr;
    io_rd && !day_carry && io_addr == 16'h00E4
    ##1 io_wr && !io_rd && !ctrl_reg[0] && !day_carry && io_addr == 16'h00E4
    ##1 io_rd && !io_wr && !day_carry && io_addr == 16'h00E4 |=> io_rdata == $past(io_rdata, 2);
  endproperty
  a_lkwr: assert property (p_lkwr) else $error("locked day write took effect");
  property p_alm;
    io_wr && (io_addr == 16'h00E8 || io_addr == 16'h00E9) ##1 io_rd && !io_wr && $stable(io_addr)
    |=> io_rdata == $past(io_wdata, 2);
  endproperty
  a_alm: assert property (p_alm) else $error("alarm target write lost");
  property p_keep;
    !ev |=> $stable({alarm_s_match, alarm_m_match, alarm_sm_match});
  endproperty
  a_keep: assert property (p_keep) else $error("match changed without evaluation");
  property p_soff;
    ev && !alm_s_en |=> !alarm_s_match;
  endproperty
  a_soff: assert property (p_soff) else $error("disabled seconds match set");
  property p_none;
    ev && !alm_s_en && !alm_m_en |=> !alarm_sm_match;
  endproperty
  a_none: assert property (p_none) else $error("combined match with no field on");
  property p_both;
    ev && alm_s_en && alm_m_en |=> alarm_sm_match == (alarm_s_match && alarm_m_match);
  endproperty
  a_both: assert property (p_both) else $error("combined match wrong");
  property p_cause;
    hundr_carry |-> $past(day_carry) && !$past(ctrl_reg[0]);
  endproperty
  a_cause: assert property (p_cause) else $error("carry without locked day carry");
  property p_pulse;
    hundr_carry |=> !hundr_carry;
  endproperty
  a_pulse: assert property (p_pulse) else $error("carry longer than a cycle");
endmodule // rtcca_chk

bind rtcca_top rtcca_chk i_rtcca_chk (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
  .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .ctrl_reg(ctrl_reg),
  .alm_s_en(alm_s_en), .alm_m_en(alm_m_en), .count_tick(count_tick), .day_carry(day_carry),
  .alarm_s_match(alarm_s_match), .alarm_m_match(alarm_m_match),
  .alarm_sm_match(alarm_sm_match), .hundr_carry(hundr_carry));
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// Register-level bench for the calendar and alarm slice
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0]  io_wdata = 8'h00, ctrl_reg = 8'h00, sec_count = 8'h00, min_count = 8'h00;
  logic        io_wr = 1'b0, io_rd = 1'b0, alm_s_en = 1'b0, alm_m_en = 1'b0;
  logic        count_tick = 1'b0, day_carry = 1'b0;
  wire logic [7:0] io_rdata;
  wire logic   io_hit, alarm_s_match, alarm_m_match, alarm_sm_match, hundr_carry;
  int          bad_count = 0;
  int          compares = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  // Device under test
  rtcca_top i_rtcca_top (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit), .ctrl_reg(ctrl_reg),
    .alm_s_en(alm_s_en),
    .alm_m_en(alm_m_en), .count_tick(count_tick), .day_carry(day_carry), .sec_count(sec_count),
    .min_count(min_count), .alarm_s_match(alarm_s_match), .alarm_m_match(alarm_m_match),
    .alarm_sm_match(alarm_sm_match), .hundr_carry(hundr_carry));
  // Byte compare
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One cycle of stimulus: each strobe is set once, then one clock edge passes
  task automatic drv(input logic w, input logic r, input logic tk, input logic dc,
                     input logic [15:0] a, input logic [7:0] d);
    io_wr = w;
    io_rd = r;
    count_tick = tk;
    day_carry = dc;
    io_addr = a;
    io_wdata = d;
    @(negedge clk);
  endtask
  // Bus cycles, entered at a falling edge; strobes stay until the next cycle is driven
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    drv(1'b1, 1'b0, 1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    drv(1'b0, 1'b1, 1'b0, 1'b0, a, io_wdata);
    chk("io_rdata", e, io_rdata);
    chk("io_hit", {7'h00, (a >= 16'h00E4 && a <= 16'h00E9)}, {7'h00, io_hit});
  endtask
  // One tick or one day carry
  task automatic pulse(input logic tk);
    drv(1'b0, 1'b0, tk, !tk, io_addr, io_wdata);
  endtask
  // Quiet cycles with every strobe low
  task automatic idle(input int n);
    repeat (n) drv(1'b0, 1'b0, 1'b0, 1'b0, io_addr, io_wdata);
  endtask
  // Four calendar counts, day first
  task automatic setc(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(16'h00E4 + 16'(i), v[31-8*i -: 8]);
  endtask
  task automatic getc(input logic [31:0] v);
    for (int i = 0; i < 4; i++) rd(16'h00E4 + 16'(i), v[31-8*i -: 8]);
  endtask
  task automatic mt(input logic [7:0] e);
    chk("match", e, {5'h00, alarm_s_match, alarm_m_match, alarm_sm_match});
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  initial begin
    #40000;
    bad_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    logic [65:0] cs [8] = '{{2'b01, 32'h1F0C6363, 32'h01010000}, {2'b00, 32'h1F011800, 32'h01021800},
      {2'b00, 32'h1E041800, 32'h01051800}, {2'b10, 32'h28022420, 32'h29022420},
      {2'b10, 32'h28022320, 32'h01032320}, {2'b10, 32'h28020020, 32'h29020020},
      {2'b10, 32'h28020019, 32'h01030019}, {2'b11, 32'h31129999, 32'h01010000}};
    repeat (16) @(negedge clk);
    rst = 1'b0;
    ctrl_reg = 8'h01;
    wr(16'h00E4, 8'h1F);
    rd(16'h00E4, 8'h1F);
    setc(32'h1F0C6363);
    wr(16'h00E8, 8'h3B);
    rd(16'h00E8, 8'h3B);
    wr(16'h00E9, 8'h3B);
    rd(16'h00E9, 8'h3B);
    rd(16'h00F0, 8'h00);
    pulse(1'b0);
    getc(32'h1F0C6363);
    ctrl_reg = 8'h00;
    rd(16'h00E4, 8'h1F);
    wr(16'h00E4, 8'h05);
    rd(16'h00E4, 8'h1F);
    setc(32'h05050505);
    getc(32'h1F0C6363);
    wr(16'h00E8, 8'h00);
    rd(16'h00E8, 8'h00);
    rd(16'h00E9, 8'h3B);
    rst = 1'b1;
    idle(16);
    rst = 1'b0;
    chk("io_rdata", 8'h00, io_rdata);
    getc(32'h1F0C6363);
    rd(16'h00E8, 8'h00);
    foreach (cs[i]) begin
      ctrl_reg = {2'b00, cs[i][65], 5'h01};
      setc(cs[i][63:32]);
      ctrl_reg[0] = 1'b0;
      pulse(1'b0);
      chk("hundr_carry", {7'h00, cs[i][64]}, {7'h00, hundr_carry});
      getc(cs[i][31:0]);
    end
    ctrl_reg = 8'h21;
    wr(16'h00E8, 8'h25);
    wr(16'h00E9, 8'h10);
    sec_count = 8'h25;
    min_count = 8'h10;
    alm_s_en = 1'b1;
    alm_m_en = 1'b1;
    ctrl_reg = 8'h20;
    pulse(1'b1);
    mt(8'h07);
    sec_count = 8'h26;
    pulse(1'b1);
    mt(8'h02);
    alm_s_en = 1'b0;
    alm_m_en = 1'b0;
    pulse(1'b1);
    mt(8'h00);
    alm_s_en = 1'b1;
    sec_count = 8'h25;
    ctrl_reg = 8'h21;
    pulse(1'b1);
    mt(8'h00);
    ctrl_reg = 8'h20;
    idle(1);
    mt(8'h05);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
